// [psc_ctrl.sv]
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Chain is 144 bits: seven 18-bit counters, pump and filter sections.
// [RULE2] Each counter: 8-bit high, 8-bit low, bypass and odd-duty bits.
// [RULE3] First bit shifted in is the low-count LSB of output counter four.
// [RULE4] Last bit shifted in is the filter section MSB.
// [RULE5] Pump current code only 000, 100, 110 or 111.
// [RULE6] Filter resistor only 0,3,4,8,16,19,20,24,27,28,30.
// [RULE7] Filter capacitor only 0, 1 or 3.
// [RULE8] Bypass bit set divides by one; clear uses high and low counts.
// [RULE9] A step moves selected taps one eighth period up or down.
// [RULE10] Output clocks keep running during a phase step.
// [RULE11] Select 000 all outputs, 001 feedback, 010 to 110 outputs 0 to 4.
// [RULE12] Direction 1 means later, 0 earlier; captured on rising edge.
// [RULE13] Step request sampled on falling edge; held two cycles by controller.
// [RULE14] Second rising edge after sampling captures inputs and starts step.
// [RULE15] Done flag falls at that edge, rises when the step ends.
// [RULE16] Controller sets direction and select before requesting; the host model drives them on the same edge as the request.
// [RULE17] Controller drops request only after done goes low.
// [RULE18] Controller waits for done to rise; pulses one cycle apart.
// [RULE19] Each request pulse gives exactly one step, without limit.
// [RULE20] Step handshake shares the free-running scan clock.
// [RULE21] Controller raises shift enable a cycle early, drops it after.
// [RULE22] Update pulse copies the chain into the active configuration.
// [RULE23] Reconfig-done high while applying; its fall means all updated.
// [RULE24] Odd bit moves half a cycle from high time to low time.
// [RULE25] Chain holds without shift enable; active set changes on update.
module psc_ctrl
	import psc_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                scan_data,
	input  wire logic                scan_ena,
	input  wire logic                config_update,
	output logic                     recfg_done,
	input  wire logic                phase_step,
	input  wire logic                phase_updown,
	input  wire logic [2:0]          phase_sel,
	output logic                     phase_done,
	output logic [N_TAP*TAP_W-1:0]   tap_sel,
	output logic [N_CNT-1:0]         div_clk,
	output logic [PUMP_W-1:0]        pump_current_field,
	output logic [LFR_W-1:0]         filter_resistor_field,
	output logic [LFC_W-1:0]         filter_capacitor_field,
	input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready
);

	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------
	function automatic logic [N_TAP-1:0] step_mask(input logic [2:0] s);
		logic [N_TAP-1:0] m;
		m = '0;
		if (s == SEL_ALL)
			m = {1'b0, {(N_TAP-1){1'b1}}};
		else if (s == SEL_M)
			m[TAP_M] = 1'b1;
		else if (s >= SEL_C0 && s <= SEL_C4)
			m[3'(s - SEL_C0)] = 1'b1;
		return m;
	endfunction

	function automatic logic pump_ok(input logic [PUMP_W-1:0] v);
		return v == 3'h0 || v == 3'h4 || v == 3'h6 || v == 3'h7;
	endfunction

	function automatic logic lfr_ok(input logic [LFR_W-1:0] v);
		case (v)
			5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13,
			5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic lfc_ok(input logic [LFC_W-1:0] v);
		return v != 2'h2;
	endfunction

	// ---------------------------------------------------------------
	// Scan chain and active configuration
	// ---------------------------------------------------------------
	logic [CHAIN_W-1:0]        chain_r;
	logic [CP_LSB-1:0]         cnt_act_r;
	logic [2*ANA_W-1:0]        ana_act_r;
	logic                      recfg_done_r;
	logic [BUSY_CW-1:0]        rcfg_cnt_r;
	logic                      err_r;
	logic                      ctrl_rej_r;
	logic [CFGSEL_W-1:0]       cfg_sel_r;
	logic                      upd_go;
	logic                      analog_ok;
	logic                      err_clr;

	// Update while a previous one is still being applied is ignored
	assign upd_go    = config_update && !recfg_done_r;
	assign analog_ok = pump_ok(chain_r[CP_LSB +: PUMP_W]) &&
		lfr_ok(chain_r[LF_LSB+LFR_LSB +: LFR_W]) &&
		lfc_ok(chain_r[LF_LSB+LFC_LSB +: LFC_W]);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_r <= '0;
		end else if (scan_ena) begin
			chain_r <= {scan_data, chain_r[CHAIN_W-1:1]}; // [RULE1] [RULE3] [RULE4]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_act_r <= '0;
		end else if (upd_go) begin
			cnt_act_r <= chain_r[CP_LSB-1:0]; // [RULE22] [RULE25]
		end
	end

	// Illegal analog codes are kept out only when rejection is enabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ana_act_r <= '0;
		end else if (upd_go && (analog_ok || !ctrl_rej_r)) begin
			ana_act_r <= chain_r[CHAIN_W-1:CP_LSB]; // [RULE5] [RULE6] [RULE7]
		end
	end

	assign pump_current_field     = ana_act_r[PUMP_W-1:0];
	assign filter_resistor_field  = ana_act_r[ANA_W+LFR_LSB +: LFR_W];
	assign filter_capacitor_field = ana_act_r[ANA_W+LFC_LSB +: LFC_W];
	assign recfg_done             = recfg_done_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			recfg_done_r <= 1'b0;
			rcfg_cnt_r   <= '0;
		end else if (upd_go) begin
			recfg_done_r <= 1'b1; // [RULE23]
			rcfg_cnt_r   <= BUSY_CW'(RCFG_BUSY_CYC - 1);
		end else if (recfg_done_r) begin
			if (rcfg_cnt_r == '0)
				recfg_done_r <= 1'b0; // [RULE23]
			else
				rcfg_cnt_r <= BUSY_CW'(rcfg_cnt_r - 1'b1);
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			err_r <= 1'b0;
		else if (upd_go && !analog_ok)
			err_r <= 1'b1; // [RULE5] [RULE6] [RULE7]
		else if (err_clr)
			err_r <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Output dividers
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_CNT; gi++) begin : g_div
			// Never paused or reset by a phase step
			psc_div u_div (
				.clk   (clk),
				.rst_n (rst_n),
				.hi    (cnt_act_r[gi*SEC_W+F_HI_LSB +: CNT_W]), // [RULE2]
				.lo    (cnt_act_r[gi*SEC_W+F_LO_LSB +: CNT_W]), // [RULE2]
				.odd   (cnt_act_r[gi*SEC_W+F_ODD]), // [RULE2] [RULE24]
				.byp   (cnt_act_r[gi*SEC_W+F_BYP]), // [RULE2] [RULE8] [RULE10]
				.clk_o (div_clk[gi])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Phase step handshake
	// ---------------------------------------------------------------
	psc_step_st_t          state_r;
	logic                  stp_neg_r;
	logic                  stp_prev_r;
	logic                  dir_r;
	logic [2:0]            sel_r;
	logic [BUSY_CW-1:0]    step_cnt_busy_r;
	logic                  phase_done_r;
	logic                  step_fire;
	logic [N_TAP-1:0]      mask;
	logic [STEPCNT_W-1:0]  step_cnt_r;

	// Same free-running clock as the chain, falling edge
	always_ff @(negedge clk or negedge rst_n) begin
		if (!rst_n)
			stp_neg_r <= 1'b0;
		else
			stp_neg_r <= phase_step; // [RULE13] [RULE20]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			stp_prev_r <= 1'b0;
		else
			stp_prev_r <= stp_neg_r;
	end

	assign step_fire  = (state_r == ST_RUN) && (step_cnt_busy_r == '0);
	assign mask       = step_mask(sel_r); // [RULE11]
	assign phase_done = phase_done_r;

	// Edge detect gives one step per pulse, however long it is held
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r         <= ST_IDLE;
			dir_r           <= 1'b0;
			sel_r           <= SEL_ALL;
			step_cnt_busy_r <= '0;
			phase_done_r    <= 1'b1;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (stp_neg_r && !stp_prev_r)
						state_r <= ST_ARM; // [RULE19]
				end
				ST_ARM: begin
					dir_r           <= phase_updown; // [RULE12] [RULE14]
					sel_r           <= phase_sel; // [RULE11] [RULE14]
					phase_done_r    <= 1'b0; // [RULE15]
					step_cnt_busy_r <= BUSY_CW'(STEP_BUSY_CYC - 1);
					state_r         <= ST_RUN;
				end
				ST_RUN: begin
					if (step_cnt_busy_r == '0) begin
						phase_done_r <= 1'b1; // [RULE15]
						state_r      <= ST_IDLE;
					end else begin
						step_cnt_busy_r <= BUSY_CW'(step_cnt_busy_r - 1'b1);
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Wraps silently; steps themselves are unlimited
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			step_cnt_r <= '0;
		else if (step_fire)
			step_cnt_r <= STEPCNT_W'(step_cnt_r + 1'b1); // [RULE19]
	end

	generate
		for (gi = 0; gi < N_TAP; gi++) begin : g_tap
			psc_tap u_tap (
				.clk   (clk),
				.rst_n (rst_n),
				.step  (step_fire && mask[gi]), // [RULE9]
				.up    (dir_r), // [RULE12]
				.tap   (tap_sel[gi*TAP_W +: TAP_W])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	logic                awready_r;
	logic                wready_r;
	logic                bvalid_r;
	logic [1:0]          bresp_r;
	logic [AXI_AW-1:0]   aw_addr_r;
	logic [31:0]         w_data_r;
	logic [3:0]          w_strb_r;
	logic                arready_r;
	logic                rvalid_r;
	logic [1:0]          rresp_r;
	logic [31:0]         rdata_r;
	logic                wr_go;
	logic [31:0]         rd_word;
	logic                rd_hit;
	logic                wr_hit;

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	assign wr_go  = !awready_r && !wready_r && !bvalid_r;
	assign wr_hit = aw_addr_r == REG_CTRL || aw_addr_r == REG_STATUS ||
		aw_addr_r == REG_CFGSEL || aw_addr_r == REG_CFGDAT ||
		aw_addr_r == REG_TAPS || aw_addr_r == REG_STEPS;
	assign err_clr = wr_go && aw_addr_r == REG_STATUS && w_strb_r[0] &&
		w_data_r[ST_ERR];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_r <= 1'b1;
			aw_addr_r <= '0;
		end else if (s_axi_awvalid && awready_r) begin
			awready_r <= 1'b0;
			aw_addr_r <= s_axi_awaddr;
		end else if (bvalid_r && s_axi_bready) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wready_r <= 1'b1;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && wready_r) begin
			wready_r <= 1'b0;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (bvalid_r && s_axi_bready) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLV;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_rej_r <= CTRL_RST;
			cfg_sel_r  <= '0;
		end else if (wr_go && w_strb_r[0]) begin
			if (aw_addr_r == REG_CTRL)
				ctrl_rej_r <= w_data_r[CTRL_REJ];
			if (aw_addr_r == REG_CFGSEL)
				cfg_sel_r <= w_data_r[CFGSEL_W-1:0];
		end
	end

	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			REG_CTRL:   rd_word[CTRL_REJ] = ctrl_rej_r;
			REG_STATUS: begin
				rd_word[ST_PDONE] = phase_done_r;
				rd_word[ST_RDONE] = recfg_done_r;
				rd_word[ST_ERR]   = err_r;
				rd_word[ST_BUSY]  = state_r != ST_IDLE;
			end
			REG_CFGSEL: rd_word[CFGSEL_W-1:0] = cfg_sel_r;
			REG_CFGDAT: begin
				if (cfg_sel_r < CFGSEL_W'(N_CNT))
					rd_word[SEC_W-1:0] = cnt_act_r[cfg_sel_r*SEC_W +: SEC_W];
				else if (cfg_sel_r < CFGSEL_W'(N_CNT + 2))
					rd_word[ANA_W-1:0] =
						ana_act_r[(cfg_sel_r-CFGSEL_W'(N_CNT))*ANA_W +: ANA_W];
			end
			REG_TAPS:   rd_word[N_TAP*TAP_W-1:0] = tap_sel;
			REG_STEPS:  rd_word[STEPCNT_W-1:0] = step_cnt_r;
			default:    rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= '0;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLV;
			rdata_r   <= rd_word;
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_shift_in;
		@(posedge clk) disable iff (!rst_n)
		scan_ena |=> chain_r == {$past(scan_data), $past(chain_r[CHAIN_W-1:1])};
	endproperty
	a_shift_in: assert property (p_shift_in) // [RULE3] [RULE4]
		else $error("scan chain did not shift toward bit zero");

	property p_chain_hold;
		@(posedge clk) disable iff (!rst_n)
		!scan_ena |=> $stable(chain_r);
	endproperty
	a_chain_hold: assert property (p_chain_hold) // [RULE25]
		else $error("scan chain moved without shift enable");

	property p_copy;
		@(posedge clk) disable iff (!rst_n)
		upd_go |=> cnt_act_r == $past(chain_r[CP_LSB-1:0]);
	endproperty
	a_copy: assert property (p_copy) // [RULE22]
		else $error("update did not copy counter settings");

	property p_act_hold;
		@(posedge clk) disable iff (!rst_n)
		!upd_go |=> $stable(cnt_act_r) && $stable(ana_act_r);
	endproperty
	a_act_hold: assert property (p_act_hold) // [RULE25]
		else $error("active configuration changed without update");

	property p_rcfg;
		@(posedge clk) disable iff (!rst_n)
		upd_go |=> recfg_done_r[*3] ##[1:16] !recfg_done_r;
	endproperty
	a_rcfg: assert property (p_rcfg) // [RULE23]
		else $error("reconfig done did not pulse around update");

	property p_reject;
		@(posedge clk) disable iff (!rst_n)
		upd_go && ctrl_rej_r && !analog_ok |=> $stable(ana_act_r) && err_r;
	endproperty
	a_reject: assert property (p_reject) // [RULE5] [RULE6] [RULE7]
		else $error("illegal analog code was applied or not flagged");

	sequence s_req;
		stp_neg_r && !stp_prev_r && state_r == ST_IDLE;
	endsequence
	sequence s_arm;
		state_r == ST_ARM ##1 !phase_done_r && state_r == ST_RUN;
	endsequence
	property p_done_fall;
		@(posedge clk) disable iff (!rst_n)
		s_req |=> s_arm;
	endproperty
	a_done_fall: assert property (p_done_fall) // [RULE14] [RULE15]
		else $error("done did not fall on second edge after request");

	property p_done_rise;
		@(posedge clk) disable iff (!rst_n)
		$fell(phase_done_r) |-> ##[1:16] phase_done_r;
	endproperty
	a_done_rise: assert property (p_done_rise) // [RULE15]
		else $error("phase done did not return high");

	property p_capture;
		@(posedge clk) disable iff (!rst_n)
		state_r == ST_ARM |=> dir_r == $past(phase_updown) &&
			sel_r == $past(phase_sel);
	endproperty
	a_capture: assert property (p_capture) // [RULE12] [RULE14]
		else $error("direction or select not captured at arm");

	property p_tap_up;
		@(posedge clk) disable iff (!rst_n)
		step_fire && dir_r && sel_r == SEL_C0 |=>
			tap_sel[TAP_W-1:0] == 3'($past(tap_sel[TAP_W-1:0]) + 3'h1);
	endproperty
	a_tap_up: assert property (p_tap_up) // [RULE9]
		else $error("tap did not advance by one");

	property p_all_keeps_m;
		@(posedge clk) disable iff (!rst_n)
		step_fire && sel_r == SEL_ALL |=>
			$stable(tap_sel[TAP_M*TAP_W +: TAP_W]);
	endproperty
	a_all_keeps_m: assert property (p_all_keeps_m) // [RULE11]
		else $error("all-outputs select moved the feedback tap");

	property p_one_step;
		@(posedge clk) disable iff (!rst_n)
		step_fire |=> !step_fire &&
			step_cnt_r == STEPCNT_W'($past(step_cnt_r) + 1'b1);
	endproperty
	a_one_step: assert property (p_one_step) // [RULE19]
		else $error("request did not give exactly one step");
endmodule

// [psc_pkg.sv]
package psc_pkg;

	// ---------------------------------------------------------------
	// Scan chain layout
	// ---------------------------------------------------------------
	localparam int CHAIN_W  = 144;
	localparam int SEC_W    = 18;
	localparam int N_CNT    = 7;
	localparam int CNT_W    = 8;
	localparam int F_LO_LSB = 0;
	localparam int F_ODD    = 8;
	localparam int F_HI_LSB = 9;
	localparam int F_BYP    = 17;
	localparam int CP_LSB   = N_CNT * SEC_W;
	localparam int ANA_W    = 9;
	localparam int LF_LSB   = CP_LSB + ANA_W;
	localparam int PUMP_W   = 3;
	localparam int LFR_W    = 5;
	localparam int LFR_LSB  = 0;
	localparam int LFC_W    = 2;
	localparam int LFC_LSB  = 5;

	// ---------------------------------------------------------------
	// Phase taps and counter select codes
	// ---------------------------------------------------------------
	localparam int TAP_W = 3;
	localparam int N_TAP = 6;
	localparam int TAP_M = 5;
	localparam logic [2:0] SEL_ALL = 3'h0;
	localparam logic [2:0] SEL_M   = 3'h1;
	localparam logic [2:0] SEL_C0  = 3'h2;
	localparam logic [2:0] SEL_C4  = 3'h6;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int         AXI_AW     = 8;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CFGSEL = 8'h08;
	localparam logic [7:0] REG_CFGDAT = 8'h0C;
	localparam logic [7:0] REG_TAPS   = 8'h10;
	localparam logic [7:0] REG_STEPS  = 8'h14;
	localparam int CTRL_REJ    = 0;
	localparam int ST_PDONE    = 0;
	localparam int ST_RDONE    = 1;
	localparam int ST_ERR      = 2;
	localparam int ST_BUSY     = 3;
	localparam int CFGSEL_W    = 4;
	localparam int STEPCNT_W   = 16;
	localparam logic       CTRL_RST   = 1'b0;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;

	// ---------------------------------------------------------------
	// Timing counts in scan clock cycles
	// ---------------------------------------------------------------
	localparam int RCFG_BUSY_CYC = 4;
	localparam int STEP_BUSY_CYC = 1;
	localparam int BUSY_CW       = 4;

	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN} psc_step_st_t;

endpackage

// [psc_div.sv]
`timescale 1ns/1ps
module psc_div
	import psc_pkg::*;
#(
	parameter int CW = CNT_W
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [CW-1:0] hi,
	input  wire logic [CW-1:0] lo,
	input  wire logic          odd,
	input  wire logic          byp,
	output logic               clk_o
);
	// One clk is half a period of the source; this allows half steps
	logic [CW+1:0] cnt_r;
	logic          clk_o_r;
	logic [CW+1:0] hi_h;
	logic [CW+1:0] lo_h;
	logic [CW+1:0] lim;

	assign hi_h = {1'b0, hi, 1'b0} - {{(CW+1){1'b0}}, odd && (hi != '0)}; // [RULE24]
	assign lo_h = {1'b0, lo, 1'b0} + {{(CW+1){1'b0}}, odd && (hi != '0)}; // [RULE24]
	assign lim  = clk_o_r ? hi_h : lo_h;
	assign clk_o = clk_o_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r   <= '0;
			clk_o_r <= 1'b0;
		end else if (byp) begin
			cnt_r   <= '0; // [RULE8]
			clk_o_r <= ~clk_o_r; // [RULE8]
		end else if ((CW+2)'(cnt_r + 1'b1) >= lim) begin
			cnt_r   <= '0; // [RULE8]
			clk_o_r <= ~clk_o_r;
		end else begin
			cnt_r <= (CW+2)'(cnt_r + 1'b1);
		end
	end

	property p_byp_toggle;
		@(posedge clk) disable iff (!rst_n)
		byp |=> clk_o_r != $past(clk_o_r);
	endproperty
	a_byp_toggle: assert property (p_byp_toggle) // [RULE8]
		else $error("bypassed divider did not divide by one");
endmodule

// [psc_tap.sv]
`timescale 1ns/1ps
module psc_tap
	import psc_pkg::*;
#(
	parameter int TW = TAP_W
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          step,
	input  wire logic          up,
	output logic [TW-1:0]      tap
);
	// Tap wraps around: eight taps make one full source period
	logic [TW-1:0] tap_r;

	assign tap = tap_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_r <= '0;
		end else if (step) begin
			tap_r <= up ? TW'(tap_r + 1'b1) : TW'(tap_r - 1'b1); // [RULE9]
		end
	end
endmodule

// [psc_host.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Reconfiguration controller model
// ----------------------------------------
module psc_host
	import psc_pkg::*;
(
	input  wire logic clk,
	input  wire logic phase_done,
	output logic      scan_data,
	output logic      scan_ena,
	output logic      config_update,
	output logic      phase_step,
	output logic      phase_updown,
	output logic [2:0] phase_sel
);
	initial begin
		{scan_data, scan_ena, config_update, phase_step, phase_updown} = '0;
		phase_sel = 3'h0;
	end
	task automatic shift(input logic [CHAIN_W-1:0] v);
		int i;
		@(posedge clk);
		// Enable leads the data by a cycle; the spare shift falls off
		scan_ena <= 1'b1;
		for (i = 0; i < CHAIN_W; i++) begin
			@(posedge clk);
			scan_data <= v[i];
		end
		@(posedge clk);
		scan_ena <= 1'b0;
		scan_data <= ~v[CHAIN_W-1];
	endtask
	task automatic pulse;
		@(posedge clk);
		config_update <= 1'b1;
		@(posedge clk);
		config_update <= 1'b0;
	endtask
	task automatic step(input logic up, input logic [2:0] s, output logic ok);
		int i;
		int j;
		@(posedge clk);
		phase_updown <= up;
		phase_sel <= s;
		phase_step <= 1'b1;
		for (i = 0; i < 20 && phase_done; i++) @(posedge clk);
		phase_step <= 1'b0;
		for (j = 0; j < 20 && !phase_done; j++) @(posedge clk);
		ok = i < 20 && j < 20;
	endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: %h vs %h", $time, a, e); end end
module testbench
	import psc_pkg::*;
;
	logic clk, rst_n, scan_data, scan_ena, config_update, recfg_done;
	logic phase_step, phase_updown, phase_done, div_prev;
	logic [2:0] phase_sel, pump_current_field;
	logic [17:0] tap_sel, exp_t;
	logic [6:0] div_clk;
	logic [4:0] filter_resistor_field;
	logic [1:0] filter_capacitor_field, s_axi_bresp, s_axi_rresp;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int fail_count = 0;
	int n_compared = 0;
	psc_ctrl DUT (.clk, .rst_n, .scan_data, .scan_ena, .config_update,
		.recfg_done, .phase_step, .phase_updown, .phase_sel, .phase_done,
		.tap_sel, .div_clk, .pump_current_field, .filter_resistor_field,
		.filter_capacitor_field, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	psc_host u_host (.clk, .phase_done, .scan_data, .scan_ena,
		.config_update, .phase_step, .phase_updown, .phase_sel);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task tmo(input logic hung);
		if (hung) begin
			fail_count++;
			print_verdict();
		end
	endtask
	function automatic logic [143:0] mk(logic [2:0] p, logic [4:0] r, logic c);
		mk = '0;
		mk[17:0] = 18'h0A5C3;
		mk[125:108] = 18'h20603;
		mk[128:126] = p;
		mk[139:135] = r;
		mk[141:140] = {c, c};
		mk[143] = 1'b1;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		tmo(i == 50);
		`CHK(s_axi_bresp, RESP_OKAY)
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int i;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		tmo(i == 50);
		`CHK(s_axi_rresp, er)
		`CHK(s_axi_rdata, e)
	endtask
	task automatic upd;
		logic [3:0] n;
		u_host.pulse();
		n = 4'h0;
		repeat (10) begin
			@(posedge clk);
			n = n + {3'h0, recfg_done};
		end
		`CHK(n, 4'(RCFG_BUSY_CYC))
	endtask
	task automatic stp(input logic up, input logic [2:0] s);
		logic ok;
		int k;
		u_host.step(up, s, ok);
		tmo(!ok);
		for (k = 0; k < 6; k++)
			if ((s == SEL_ALL && k < 5) || (s == SEL_M && k == 5) ||
				(s >= SEL_C0 && s <= SEL_C4 && k == s - 2))
				exp_t[3*k +: 3] = exp_t[3*k +: 3] + (up ? 3'h1 : 3'h7);
		`CHK(tap_sel, exp_t)
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		tmo(1'b1);
	end
	initial begin
		rst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		exp_t = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		u_host.shift(mk(3'h6, 5'h1B, 1'b1));
		`CHK(pump_current_field, 3'h0)
		upd();
		`CHK(pump_current_field, 3'h6)
		`CHK(filter_resistor_field, 5'h1B)
		`CHK(filter_capacitor_field, 2'h3)
		// Bypassed feedforward counter with counts 3/3 must toggle each clk
		repeat (2) begin
			div_prev = div_clk[6];
			@(posedge clk);
			`CHK(div_clk[6], ~div_prev)
		end
		wr(REG_CFGSEL, 32'h0);
		rc(REG_CFGDAT, 32'h0000A5C3, RESP_OKAY);
		wr(REG_CFGSEL, 32'h8);
		rc(REG_CFGDAT, 32'h0000017B, RESP_OKAY);
		wr(REG_CTRL, 32'h1);
		u_host.shift(mk(3'h2, 5'h1B, 1'b1));
		upd();
		`CHK(pump_current_field, 3'h6)
		rc(REG_STATUS, 32'h5, RESP_OKAY);
		wr(REG_CFGSEL, 32'h7);
		rc(REG_CFGDAT, 32'h00000006, RESP_OKAY);
		wr(REG_STATUS, 32'h4);
		rc(REG_STATUS, 32'h1, RESP_OKAY);
		rc(8'h20, 32'h0, RESP_SLV);
		for (int s = 0; s < 8; s++) stp(1'b1, 3'(s));
		stp(1'b0, SEL_M);
		stp(1'b0, SEL_M);
		rc(REG_STEPS, 32'h0000000A, RESP_OKAY);
		rc(REG_TAPS, {14'h0, exp_t}, RESP_OKAY);
		print_verdict();
	end
endmodule
